// >>> inc/sapp_pkg.sv
// constants shared by the converter control port and its conversion engine
// assumes one 100 MHz clock and a synchronous active-high reset
package sapp_pkg;
   // result, lane and pad widths
   localparam int RES_W = 12;
   localparam int LANE_W = 8;
   localparam int PAD_W = 4;
   // trial mask for the first successive-approximation step
   localparam logic [11:0] RES_MSB_MASK = 12'h800;
   // default length of one conversion in clock cycles, at least RES_W
   localparam int CONV_CYCLES_DEF = 16;
   // reset values
   localparam logic BUSY_N_RST = 1'b1;
   localparam logic [11:0] RESULT_RST = 12'h000;
   localparam logic [7:0] LANE_RST = 8'h00;
   localparam logic [3:0] PAD_LOW = 4'h0;
   // idle levels of the synchronised control pins
   localparam logic CS_N_RST = 1'b1;
   localparam logic RC_RST = 1'b1;
endpackage

// >>> inc/sapp_conv_if.sv
// signals between the port control and the conversion engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface sapp_conv_if;
   logic start;
   logic [11:0] sample;
   logic done;
   logic [11:0] result;
   logic running;
   modport ctrl (output start, output sample, input done, input result,
      input running);
   modport eng (input start, input sample, output done, output result,
      output running);
endinterface
`default_nettype wire

// >>> design/sapp_conv.sv
// successive-approximation engine: holds a sample and resolves it bit by bit
// assumes start is a one-cycle pulse that arrives only while idle
`timescale 1ns/1ps
`default_nettype none
module sapp_conv #(
   parameter int CONV_CYCLES = sapp_pkg::CONV_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic srst,
   sapp_conv_if.eng cif
);
   localparam int CNT_W = $clog2(CONV_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

   typedef enum logic {C_IDLE, C_RUN} sapp_cst_e;
   sapp_cst_e state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [11:0] hold_q;
   logic [11:0] trial_q;
   logic [11:0] test;
   logic done_q;

   ////////////////////////////////////////////////////////////////////////
   // next trial word; the mask runs out after the last bit, so later
   // cycles only pad the conversion to its full length
   assign test = trial_q | (sapp_pkg::RES_MSB_MASK >> cnt_q);

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= C_IDLE;
         cnt_q <= '0;
         hold_q <= sapp_pkg::RESULT_RST;
         trial_q <= sapp_pkg::RESULT_RST;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            C_IDLE: begin
               if (cif.start) begin
                  hold_q <= cif.sample; // sample goes into hold here
                  trial_q <= '0;
                  cnt_q <= '0;
                  state_q <= C_RUN;
               end
            end
            C_RUN: begin
               if (test <= hold_q) begin
                  trial_q <= test;
               end
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == CNT_LAST) begin
                  done_q <= 1'b1;
                  state_q <= C_IDLE;
               end
            end
         endcase
      end
   end

   assign cif.done = done_q;
   assign cif.result = trial_q;
   assign cif.running = (state_q == C_RUN);

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_done_count;
      @(posedge clk) disable iff (srst)
      done_q |-> $past(cnt_q) == CNT_LAST && state_q == C_IDLE;
   endproperty
   a_done_count: assert property (p_done_count)
      else $error("conversion ended at wrong count");

   property p_result_exact;
      @(posedge clk) disable iff (srst)
      done_q |-> trial_q == hold_q;
   endproperty
   a_result_exact: assert property (p_result_exact)
      else $error("approximation did not reach held sample");
endmodule
`default_nettype wire

// >>> design/sapp_top.sv
// parallel read port and conversion control of a 12-bit sampling converter
// assumes host pins are asynchronous and that three-state buffers sit
// outside, driven by the output enable below
`timescale 1ns/1ps
`default_nettype none
module sapp_top #(
   parameter int CONV_CYCLES = sapp_pkg::CONV_CYCLES_DEF
) (
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire logic I_CS_N,
   input wire logic I_RC,
   input wire logic I_BYTE,
   input wire logic [11:0] I_SAMPLE,
   output logic O_BUSY_N,
   output logic [11:0] O_RESULT,
   output logic [7:0] O_BYTE_LANE,
   output logic O_DATA_OE,
   output logic [3:0] O_ZERO_PAD_OUT
);
   localparam int SW = 15;

   sapp_conv_if cif ();

   logic [SW-1:0] meta_q;
   logic [SW-1:0] sync_q;
   logic cs_s;
   logic rc_s;
   logic byte_s;
   logic [11:0] sample_s;
   logic req_lvl;
   logic start_q;
   logic busy_n_q;
   logic [11:0] result_q;
   logic [7:0] lane_q;
   logic oe_q;
   logic [3:0] pad_q;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the sample word is not gray coded, so it must be
   // steady for two clocks around a start or a torn code may be held
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         meta_q <= {sapp_pkg::CS_N_RST, sapp_pkg::RC_RST, 13'h0000};
         sync_q <= {sapp_pkg::CS_N_RST, sapp_pkg::RC_RST, 13'h0000};
      end else begin
         meta_q <= {I_CS_N, I_RC, I_BYTE, I_SAMPLE};
         sync_q <= meta_q;
      end
   end

   assign cs_s = sync_q[14];
   assign rc_s = sync_q[13];
   assign byte_s = sync_q[12];
   assign sample_s = sync_q[11:0];

   ////////////////////////////////////////////////////////////////////////
   // ORed active-low request
   // level sensing covers both falling edges and a request still low
   // when busy rises, which restarts at once as the host is warned
   assign req_lvl = ~(cs_s | rc_s);

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         start_q <= 1'b0;
      end else begin
         start_q <= req_lvl & busy_n_q & ~start_q;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         busy_n_q <= sapp_pkg::BUSY_N_RST;
      end else if (req_lvl & busy_n_q & ~start_q) begin
         busy_n_q <= 1'b0;
      end else if (cif.done) begin
         busy_n_q <= 1'b1;
      end
   end

   assign cif.start = start_q;
   assign cif.sample = sample_s;

   sapp_conv #(
      .CONV_CYCLES(CONV_CYCLES)
   ) u_conv (
      .clk(I_CLK),
      .srst(I_SRST),
      .cif(cif)
   );

   ////////////////////////////////////////////////////////////////////////
   // offset code to two's complement
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         result_q <= sapp_pkg::RESULT_RST;
      end else if (cif.done) begin
         result_q <= {~cif.result[11], cif.result[10:0]};
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         lane_q <= sapp_pkg::LANE_RST;
      end else if (byte_s) begin
         lane_q <= result_q[7:0];
      end else begin
         lane_q <= result_q[11:4];
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= ~cs_s & rc_s;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         pad_q <= sapp_pkg::PAD_LOW;
      end else begin
         pad_q <= sapp_pkg::PAD_LOW;
      end
   end

   assign O_BUSY_N = busy_n_q;
   assign O_RESULT = result_q;
   assign O_BYTE_LANE = lane_q;
   assign O_DATA_OE = oe_q;
   assign O_ZERO_PAD_OUT = pad_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_SRST);

   property p_busy_until_write;
      $rose(busy_n_q) |-> $past(cif.done) && !cif.running;
   endproperty
   a_busy_until_write: assert property (p_busy_until_write)
      else $error("busy released without a finished conversion");

   property p_busy_during_run;
      cif.running |-> !busy_n_q;
   endproperty
   a_busy_during_run: assert property (p_busy_during_run)
      else $error("busy high while converting");

   // compares against the word the lane was loaded from, so a result
   // update on the same edge cannot trip it
   property p_lane_low_byte;
      byte_s |=> lane_q == $past(result_q[7:0]);
   endproperty
   a_lane_low_byte: assert property (p_lane_low_byte)
      else $error("low byte lane wrong");

   property p_start_on_req;
      (req_lvl && busy_n_q && !start_q) |=> start_q && !busy_n_q;
   endproperty
   a_start_on_req: assert property (p_start_on_req)
      else $error("request while idle did not start");

   property p_bus_released;
      (cs_s || !rc_s) |=> !O_DATA_OE;
   endproperty
   a_bus_released: assert property (p_bus_released)
      else $error("bus driven while not read");

   property p_read_enables;
      (!cs_s && $rose(rc_s)) |=> O_DATA_OE ##0 O_ZERO_PAD_OUT == 4'h0;
   endproperty
   a_read_enables: assert property (p_read_enables)
      else $error("read did not enable bus");

   // start rises as busy falls, so the check looks one edge ahead
   property p_no_start_busy;
      !busy_n_q |=> !start_q;
   endproperty
   a_no_start_busy: assert property (p_no_start_busy)
      else $error("start accepted while busy");

   property p_twos_comp;
      $rose(busy_n_q) |-> result_q == {~$past(cif.result[11]),
         $past(cif.result[10:0])};
   endproperty
   a_twos_comp: assert property (p_twos_comp)
      else $error("result code not two's complement");

   property p_conv_ends;
      start_q |-> ##[1:1000] $rose(busy_n_q);
   endproperty
   a_conv_ends: assert property (p_conv_ends)
      else $error("conversion did not finish");

   c_convert: cover property (start_q ##[1:1000] $rose(busy_n_q));
   c_byte_read: cover property (O_DATA_OE && byte_s ##1 !byte_s);
   c_restart: cover property ($rose(busy_n_q) && req_lvl ##1 start_q);
endmodule
`default_nettype wire

// >>> bench/sapp_host_model.sv
// host controller model: drives chip select, read/convert, byte, sample
// assumes a 100 MHz clock; it changes its pins only at falling edges
`timescale 1ns/1ps
`default_nettype none
module sapp_host_model (
   input wire logic i_clk,
   output logic o_cs_n,
   output logic o_rc,
   output logic o_byte,
   output logic [11:0] o_sample
);
   // idle: deselected, read mode
   initial begin
      o_cs_n = 1'b1;
      o_rc = 1'b1;
      o_byte = 1'b0;
      o_sample = 12'h000;
   end
   // one pin update, away from the sampling edge
   task automatic drive(input logic cs_n, input logic rc, input logic bsel,
      input logic [11:0] smp);
      @(negedge i_clk);
      o_cs_n = cs_n;
      o_rc = rc;
      o_byte = bsel;
      o_sample = smp;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // start request: the other line goes low first, so the chosen one starts
   task automatic convert(input logic by_cs, input logic [11:0] smp);
      drive(by_cs, ~by_cs, 1'b0, smp);
      drive(1'b0, 1'b0, 1'b0, smp);
      repeat (4) @(negedge i_clk);
      o_rc = 1'b1;
   endtask
endmodule
`default_nettype wire

// >>> bench/sapp_top_tb.sv
// self-checking bench for the converter port against a host model
// assumes outputs settle three edges after a pin change
`timescale 1ns/1ps
`default_nettype none
module sapp_top_tb;
   localparam int CONV = 12;
   logic clk, srst, busy_n, oe;
   logic cs_n, rc, bsel;
   logic [11:0] smp, res;
   logic [7:0] lane;
   logic [3:0] pad;
   int n_fail, comparisons, busy_cnt, busy_len;
   sapp_host_model host (.i_clk(clk), .o_cs_n(cs_n), .o_rc(rc),
      .o_byte(bsel), .o_sample(smp));
   sapp_top #(.CONV_CYCLES(CONV)) DUT (.I_CLK(clk), .I_SRST(srst),
      .I_CS_N(cs_n), .I_RC(rc), .I_BYTE(bsel), .I_SAMPLE(smp),
      .O_BUSY_N(busy_n), .O_RESULT(res), .O_BYTE_LANE(lane),
      .O_DATA_OE(oe), .O_ZERO_PAD_OUT(pad));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // length of each busy-low span, sampled where outputs are settled
   always @(negedge clk) begin
      if (busy_n === 1'b0) busy_cnt++;
      else if (busy_cnt != 0) begin
         busy_len = busy_cnt;
         busy_cnt = 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp(string what, logic [11:0] exp, logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // bounded wait: a stuck busy shows up in the length check
   task automatic wait_idle();
      for (int i = 0; i < 60 && busy_n !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
   endtask
   task automatic settle();
      repeat (4) @(negedge clk);
   endtask
   // full word, pads and both byte lanes; sample is offset binary
   task automatic read_check(logic [11:0] s);
      logic [11:0] e;
      e = {~s[11], s[10:0]};
      host.drive(1'b0, 1'b1, 1'b0, s);
      settle();
      cmp("oe", 12'h001, {11'h000, oe});
      cmp("result", e, res);
      cmp("pad", 12'h000, {8'h00, pad});
      cmp("upper lane", {4'h0, e[11:4]}, {4'h0, lane});
      host.drive(1'b0, 1'b1, 1'b1, s);
      settle();
      cmp("lower lane", {4'h0, e[7:0]}, {4'h0, lane});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // conversion, then a second request and a new sample while busy
   task automatic t_conv(logic by_cs, logic [11:0] s, logic [11:0] s2);
      busy_len = 0;
      host.convert(by_cs, s);
      cmp("busy low", 12'h000, {11'h000, busy_n});
      host.drive(1'b0, 1'b0, 1'b0, s2);
      settle();
      cmp("oe in convert", 12'h000, {11'h000, oe});
      host.drive(1'b0, 1'b1, 1'b0, s2);
      wait_idle();
      cmp("busy span", 12'(CONV + 2), 12'(busy_len));
      read_check(s);
   endtask
   task automatic t_reset();
      cmp("busy reset", 12'h001, {11'h000, busy_n});
      cmp("oe reset", 12'h000, {11'h000, oe});
      cmp("result reset", 12'h000, res);
   endtask
   // request held past busy rising restarts at once, then a clean release
   task automatic t_restart(logic [11:0] s);
      busy_len = 0;
      host.drive(1'b0, 1'b0, 1'b0, s);
      repeat (CONV + 8) @(negedge clk);
      cmp("busy restart", 12'h000, {11'h000, busy_n});
      host.drive(1'b0, 1'b1, 1'b0, s);
      wait_idle();
      cmp("restart span", 12'(CONV + 2), 12'(busy_len));
      read_check(s);
   endtask
   task automatic t_hiz();
      host.drive(1'b1, 1'b1, 1'b0, 12'h000);
      settle();
      cmp("oe deselected", 12'h000, {11'h000, oe});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
   // main sequence: reset 20 cycles, then the scenarios
   initial begin
      logic [11:0] codes [4];
      codes = '{12'h000, 12'hFFF, 12'h800, 12'h7FF};
      srst = 1'b1;
      repeat (20) @(negedge clk);
      srst = 1'b0;
      settle();
      t_reset();
      t_conv(1'b0, 12'h123, 12'hABC);
      t_conv(1'b1, 12'hA5C, 12'h3C3);
      foreach (codes[i]) t_conv(1'b0, codes[i], ~codes[i]);
      t_restart(12'h5A5);
      t_hiz();
      report_and_stop();
   end
endmodule
`default_nettype wire
